// ===== src/lcu_cfg.svh
// offsets, field positions, reset values and timing counts of the lin uart core
// assumes it is included by bare name from the package and the design modules
`ifndef LCU_CFG_SVH
`define LCU_CFG_SVH

// register byte offsets on the avalon slave
`define LCU_ADR_W        5
`define LCU_OFS_MODE     5'h00
`define LCU_OFS_CTRL     5'h04
`define LCU_OFS_BAUD     5'h08
`define LCU_OFS_TXD      5'h0C
`define LCU_OFS_RXD      5'h10
`define LCU_OFS_STAT     5'h14

// operation_mode_reg fields
`define LCU_MODE_PWR     7
`define LCU_MODE_TXE     6
`define LCU_MODE_RXE     5
`define LCU_MODE_MSB     4
`define LCU_MODE_LEN8    3
`define LCU_MODE_INV     2
`define LCU_MODE_SBRX    1

// control register fields
`define LCU_CTRL_CKS_HI  3
`define LCU_CTRL_CKS_LO  0
`define LCU_CTRL_SBL_HI  6
`define LCU_CTRL_SBL_LO  4
`define LCU_CTRL_SBTX    7

// status register fields
`define LCU_ST_TXBUSY    0
`define LCU_ST_TXFULL    1
`define LCU_ST_RXRDY     2
`define LCU_ST_OVR       3
`define LCU_ST_FRM       4
`define LCU_ST_SBFOK     5
`define LCU_ST_SBFERR    6

// reset values
`define LCU_RST_MODE     8'h00
`define LCU_RST_CTRL     8'h00
`define LCU_RST_BAUD     8'h10
`define LCU_RST_DATA     8'hFF

// counts
`define LCU_SBF_BASE     5'h0D
`define LCU_SBF_MIN      5'h0B
`define LCU_LO_SAT       5'h1F
`define LCU_GAP_LAST     2'h1
`define LCU_CKS_MAX      4'hB
`define LCU_LAST8        3'h7
`define LCU_LAST7        3'h6

`endif

// ===== src/lcu_pkg.sv
// types shared by the lin uart core modules
// assumes lcu_cfg.svh is reachable on the include path
package lcu_pkg;
  `include "lcu_cfg.svh"

  // transmit sequencer, gray along idle-start-data-stop-gap
  typedef enum logic [2:0] {
    LCU_TX_IDLE  = 3'h0,
    LCU_TX_START = 3'h1,
    LCU_TX_DATA  = 3'h3,
    LCU_TX_STOP  = 3'h2,
    LCU_TX_GAP   = 3'h6,
    LCU_TX_BRK   = 3'h4
  } lcu_tx_e;

  // receive sequencer, gray along idle-start-data-stop
  typedef enum logic [2:0] {
    LCU_RX_IDLE  = 3'h0,
    LCU_RX_START = 3'h1,
    LCU_RX_DATA  = 3'h3,
    LCU_RX_STOP  = 3'h2,
    LCU_RX_SBRK  = 3'h5
  } lcu_rx_e;

  // whole state of the core
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] ctrl;
    logic [7:0] baud;
    logic [7:0] txbuf;
    logic [7:0] txsr;
    logic [7:0] rxbuf;
    logic [7:0] rxsr;
    logic [7:0] rdata;
    logic       txfull;
    logic       sbtx_req;
    logic       tx_pin;
    logic       rx_smp;
    logic       rx_prev;
    logic       rx_rdy;
    logic       ovr;
    logic       frm;
    logic       sbf_ok;
    logic       sbf_err;
    logic       ack;
    lcu_tx_e    tx_st;
    lcu_rx_e    rx_st;
    logic [2:0] tx_idx;
    logic [2:0] rx_idx;
    logic [4:0] brk_cnt;
    logic [4:0] lo_cnt;
    logic [1:0] gap_cnt;
  } lcu_core_s;

  // state of one baud counter
  typedef struct packed {
    logic [8:0] cnt;
  } lcu_bgen_s;

  // state of the clock prescaler
  typedef struct packed {
    logic [10:0] cnt;
  } lcu_pre_s;
endpackage

// ===== src/lcu_baud_if.sv
// link between the core and one baud counter
// assumes the core drives the controls and the counter drives the ticks
`timescale 1ns/100ps
`default_nettype none
interface lcu_baud_if;
  logic       base_tick; // one-cycle base clock enable
  logic       clr;       // hold counter at zero
  logic       run;       // count base ticks
  logic [7:0] k;         // half-bit divisor
  logic       half;      // mid-bit pulse
  logic       full;      // end-of-bit pulse
  modport gen  (input base_tick, clr, run, k, output half, full);
  modport user (output base_tick, clr, run, k, input half, full);
endinterface
`default_nettype wire

// ===== src/lcu_prescaler.sv
// operating clock selector: twelve power-of-two taps of mclk
// assumes sel is stable between frames; en low stops and clears it
`timescale 1ns/100ps
`default_nettype none
`include "lcu_cfg.svh"
module lcu_prescaler
  import lcu_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic       en_i,
  input  wire logic [3:0] sel_i,
  output logic            tick_o
);
  lcu_pre_s    s_r;      // registered state
  lcu_pre_s    s_nxt;    // next state
  logic [3:0]  sel_c;    // clamped selector
  logic [10:0] mask;     // low bits that must be all ones

  // selector values above eleven fold onto the slowest tap
  always_comb begin
    sel_c  = (sel_i > `LCU_CKS_MAX) ? `LCU_CKS_MAX : sel_i;
    mask   = (11'h001 << sel_c) - 11'h001;
    tick_o = en_i & ((s_r.cnt & mask) == mask);
    s_nxt  = s_r;
    if (!en_i) begin
      s_nxt.cnt = 11'h000; // stopped unit draws no toggling
    end else begin
      s_nxt.cnt = s_r.cnt + 11'h001;
    end
  end

  // clock enable freezes the divider too
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      s_r <= '{cnt: 11'h000};
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end
endmodule
`default_nettype wire

// ===== src/lcu_baud_gen.sv
// 8-bit programmable baud counter; bit time is twice k base ticks
// assumes the user clears it while idle so each frame starts on a fresh bit
`timescale 1ns/100ps
`default_nettype none
module lcu_baud_gen
  import lcu_pkg::*;
(
  input  wire logic mclk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  lcu_baud_if.gen   bif
);
  lcu_bgen_s  s_r;    // registered state
  lcu_bgen_s  s_nxt;  // next state
  logic [8:0] k_eff;  // divisor, zero treated as one
  logic [8:0] half_c; // last count of the first half
  logic [8:0] full_c; // last count of the bit

  // ticks are combinational so the sequencer reacts in the same cycle
  always_comb begin
    k_eff    = (bif.k == 8'h00) ? 9'h001 : {1'b0, bif.k};
    half_c   = k_eff - 9'h001;
    full_c   = {k_eff[7:0], 1'b0} - 9'h001;
    bif.half = bif.run & bif.base_tick & (s_r.cnt == half_c);
    bif.full = bif.run & bif.base_tick & (s_r.cnt == full_c);
    s_nxt    = s_r;
    if (bif.clr) begin
      s_nxt.cnt = 9'h000;
    end else if (bif.run && bif.base_tick) begin
      s_nxt.cnt = bif.full ? 9'h000 : s_r.cnt + 9'h001;
    end
  end

  // frozen while the clock enable is low
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      s_r <= '{cnt: 9'h000};
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end
endmodule
`default_nettype wire

// ===== src/lcu_core.sv
// lin capable uart core: avalon-mm registers, transmitter, receiver
// assumes a synchronous rx input and a master that honours waitrequest
// Function
// - stop mode when powered off, no transfers
// - one transmit output, one receive input
// - selectable 7 or 8 data bits
// - 8-bit programmable baud generator sets timing
// - transmitter and receiver enabled independently
// - operating clock chosen from twelve sources
// - selectable msb-first or lsb-first order
// - inversion applies to transmit output only
// - break sent low for 13 to 20 bits
// - low of 11+ bits flags break received
// - keeps working while clock keeps running
// - clock stop freezes registers and output
// - two extra clocks between back-to-back frames
// - receiver restarts timing on each start bit
// - power, tx and rx enable bits gate paths
// - short break is error, stays in break mode
// - 7-bit data aligned by bit order
//
// The placing of the registers and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "lcu_cfg.svh"
module lcu_core
  import lcu_pkg::*;
(
  input  wire logic                  mclk_i,
  input  wire logic                  rst_i,
  input  wire logic                  ce_i,
  input  wire logic [`LCU_ADR_W-1:0] avs_address_i,
  input  wire logic                  avs_read_i,
  input  wire logic                  avs_write_i,
  input  wire logic [31:0]           avs_writedata_i,
  output logic      [31:0]           avs_readdata_o,
  output logic                       avs_waitrequest_o,
  input  wire logic                  lin_uart_rx_pin_i,
  output logic                       lin_uart_tx_pin_o
);
  localparam lcu_core_s RST_S = '{
    mode: `LCU_RST_MODE, ctrl: `LCU_RST_CTRL, baud: `LCU_RST_BAUD,
    txbuf: `LCU_RST_DATA, txsr: `LCU_RST_DATA, rxbuf: `LCU_RST_DATA,
    rxsr: `LCU_RST_DATA, rdata: 8'h00, tx_pin: 1'b1, rx_smp: 1'b1,
    rx_prev: 1'b1, tx_st: LCU_TX_IDLE, rx_st: LCU_RX_IDLE, tx_idx: 3'h0,
    rx_idx: 3'h0, brk_cnt: 5'h00, lo_cnt: 5'h00, gap_cnt: 2'h0, default: 1'b0};

  lcu_core_s  s_r;      // registered state
  lcu_core_s  s_nxt;    // next state
  logic       pwr;      // unit powered
  logic       tx_act;   // transmitter may run
  logic       rx_act;   // receiver may run
  logic       acc;      // bus request accepted this cycle
  logic       wr_go;    // write takes effect at this edge
  logic       rd_go;    // read completes at this edge
  logic       base;     // selected operating clock tick
  logic [2:0] last_idx; // index of final data bit
  logic [4:0] brk_last; // final break bit count
  logic [7:0] rd_mux;   // read data selected by address
  logic [7:0] stat;     // status image
  logic       tx_lvl;   // uninverted line level
  logic [7:0] rx_word;  // aligned receive word

  lcu_baud_if tx_bif ();
  lcu_baud_if rx_bif ();

  // mode decode
  always_comb begin
    pwr      = s_r.mode[`LCU_MODE_PWR];
    tx_act   = pwr & s_r.mode[`LCU_MODE_TXE];
    rx_act   = pwr & s_r.mode[`LCU_MODE_RXE];
    last_idx = s_r.mode[`LCU_MODE_LEN8] ? `LCU_LAST8 : `LCU_LAST7;
    brk_last = `LCU_SBF_BASE + {2'h0, s_r.ctrl[`LCU_CTRL_SBL_HI:`LCU_CTRL_SBL_LO]}
               - 5'h01;
  end

  // one prescaler feeds both counters; gated off in stop mode
  lcu_prescaler u_pre (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .en_i   (pwr),
    .sel_i  (s_r.ctrl[`LCU_CTRL_CKS_HI:`LCU_CTRL_CKS_LO]),
    .tick_o (base)
  );

  // separate counters so each direction times itself
  assign tx_bif.base_tick = base;
  assign tx_bif.k         = s_r.baud;
  assign tx_bif.clr       = ~tx_act | (s_r.tx_st == LCU_TX_IDLE)
                            | (s_r.tx_st == LCU_TX_GAP);
  assign tx_bif.run       = tx_act;
  assign rx_bif.base_tick = base;
  assign rx_bif.k         = s_r.baud;
  assign rx_bif.clr       = ~rx_act | (s_r.rx_st == LCU_RX_IDLE);
  assign rx_bif.run       = rx_act;

  lcu_baud_gen u_tx_bg (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .bif    (tx_bif)
  );

  lcu_baud_gen u_rx_bg (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .bif    (rx_bif)
  );

  // bus handshake: one wait cycle, answer on the second edge
  always_comb begin
    acc               = (avs_read_i | avs_write_i) & ~s_r.ack;
    avs_waitrequest_o = (avs_read_i | avs_write_i) & ~(s_r.ack & ce_i);
    wr_go             = avs_write_i & s_r.ack;
    rd_go             = avs_read_i & s_r.ack;
    avs_readdata_o    = {24'h000000, s_r.rdata};
    lin_uart_tx_pin_o = s_r.tx_pin;
  end

  // status image and read mux
  always_comb begin
    stat                   = 8'h00;
    stat[`LCU_ST_TXBUSY]   = s_r.tx_st != LCU_TX_IDLE;
    stat[`LCU_ST_TXFULL]   = s_r.txfull;
    stat[`LCU_ST_RXRDY]    = s_r.rx_rdy;
    stat[`LCU_ST_OVR]      = s_r.ovr;
    stat[`LCU_ST_FRM]      = s_r.frm;
    stat[`LCU_ST_SBFOK]    = s_r.sbf_ok;
    stat[`LCU_ST_SBFERR]   = s_r.sbf_err;
    unique case (avs_address_i)
      `LCU_OFS_MODE: rd_mux = s_r.mode;
      `LCU_OFS_CTRL: rd_mux = s_r.ctrl;
      `LCU_OFS_BAUD: rd_mux = s_r.baud;
      `LCU_OFS_TXD:  rd_mux = s_r.txbuf;
      `LCU_OFS_RXD:  rd_mux = s_r.rxbuf;
      `LCU_OFS_STAT: rd_mux = stat;
      default:       rd_mux = 8'h00; // unmapped reads zero
    endcase
  end

  // 7-bit words land low for lsb-first, high for msb-first
  always_comb begin
    if (s_r.mode[`LCU_MODE_LEN8]) begin
      rx_word = s_r.rxsr;
    end else if (s_r.mode[`LCU_MODE_MSB]) begin
      rx_word = {s_r.rxsr[6:0], 1'b0};
    end else begin
      rx_word = {1'b0, s_r.rxsr[7:1]};
    end
  end

  // next state: software first, then hardware so sets win over clears
  always_comb begin
    s_nxt       = s_r;
    s_nxt.ack   = acc;
    tx_lvl      = 1'b1;
    if (acc) begin
      s_nxt.rdata = rd_mux;
    end
    // register writes
    if (wr_go) begin
      unique case (avs_address_i)
        `LCU_OFS_MODE: s_nxt.mode = avs_writedata_i[7:0];
        `LCU_OFS_CTRL: begin
          s_nxt.ctrl     = {1'b0, avs_writedata_i[6:0]}; // trigger bit reads zero
          s_nxt.sbtx_req = s_r.sbtx_req | avs_writedata_i[`LCU_CTRL_SBTX];
        end
        `LCU_OFS_BAUD: s_nxt.baud = avs_writedata_i[7:0];
        `LCU_OFS_TXD: begin
          s_nxt.txbuf  = avs_writedata_i[7:0];
          s_nxt.txfull = 1'b1;
        end
        `LCU_OFS_STAT: begin
          // write one to clear the sticky flags
          s_nxt.ovr     = s_r.ovr & ~avs_writedata_i[`LCU_ST_OVR];
          s_nxt.frm     = s_r.frm & ~avs_writedata_i[`LCU_ST_FRM];
          s_nxt.sbf_ok  = s_r.sbf_ok & ~avs_writedata_i[`LCU_ST_SBFOK];
          s_nxt.sbf_err = s_r.sbf_err & ~avs_writedata_i[`LCU_ST_SBFERR];
        end
        default: ;
      endcase
    end
    // reading the data word frees the buffer
    if (rd_go && (avs_address_i == `LCU_OFS_RXD)) begin
      s_nxt.rx_rdy = 1'b0;
    end

    // transmitter
    unique case (s_r.tx_st)
      LCU_TX_IDLE: begin
        if (s_r.sbtx_req) begin
          s_nxt.tx_st    = LCU_TX_BRK;
          s_nxt.brk_cnt  = 5'h00;
          s_nxt.sbtx_req = 1'b0;
        end else if (s_r.txfull) begin
          s_nxt.tx_st  = LCU_TX_START;
          s_nxt.txsr   = s_r.txbuf;
          s_nxt.txfull = wr_go && (avs_address_i == `LCU_OFS_TXD); // fresh write stays queued
        end
      end
      LCU_TX_START: begin
        tx_lvl = 1'b0;
        if (tx_bif.full) begin
          s_nxt.tx_st  = LCU_TX_DATA;
          s_nxt.tx_idx = 3'h0;
        end
      end
      LCU_TX_DATA: begin
        tx_lvl = s_r.mode[`LCU_MODE_MSB] ? s_r.txsr[3'h7 - s_r.tx_idx]
                                         : s_r.txsr[s_r.tx_idx];
        if (tx_bif.full) begin
          s_nxt.tx_idx = s_r.tx_idx + 3'h1;
          if (s_r.tx_idx == last_idx) begin
            s_nxt.tx_st = LCU_TX_STOP;
          end
        end
      end
      LCU_TX_STOP: begin
        if (tx_bif.full) begin
          s_nxt.tx_st   = s_r.txfull ? LCU_TX_GAP : LCU_TX_IDLE;
          s_nxt.gap_cnt = 2'h0;
        end
      end
      LCU_TX_GAP: begin
        // back-to-back frames lose two base clocks here
        if (base) begin
          s_nxt.gap_cnt = s_r.gap_cnt + 2'h1;
          if (s_r.gap_cnt == `LCU_GAP_LAST) begin
            s_nxt.tx_st  = LCU_TX_START;
            s_nxt.txsr   = s_r.txbuf;
            s_nxt.txfull = wr_go && (avs_address_i == `LCU_OFS_TXD); // set wins
          end
        end
      end
      LCU_TX_BRK: begin
        tx_lvl = 1'b0;
        if (tx_bif.full) begin
          s_nxt.brk_cnt = s_r.brk_cnt + 5'h01;
          if (s_r.brk_cnt == brk_last) begin
            s_nxt.tx_st = LCU_TX_STOP;
          end
        end
      end
      default: s_nxt.tx_st = LCU_TX_IDLE;
    endcase
    if (!tx_act) begin
      s_nxt.tx_st    = LCU_TX_IDLE;
      s_nxt.txfull   = 1'b0;
      s_nxt.sbtx_req = 1'b0;
      tx_lvl         = 1'b1;
    end
    // idle high when off; inversion touches only this output
    s_nxt.tx_pin = pwr ? (tx_lvl ^ s_r.mode[`LCU_MODE_INV]) : 1'b1;

    // receiver input taken without inversion
    s_nxt.rx_smp  = lin_uart_rx_pin_i;
    s_nxt.rx_prev = s_r.rx_smp;
    unique case (s_r.rx_st)
      LCU_RX_IDLE: begin
        if (s_r.rx_prev && !s_r.rx_smp) begin
          s_nxt.rx_st = LCU_RX_START;
        end
      end
      LCU_RX_START: begin
        if (rx_bif.half) begin
          if (s_r.rx_smp) begin
            s_nxt.rx_st = LCU_RX_IDLE; // glitch, not a start bit
          end else if (s_r.mode[`LCU_MODE_SBRX]) begin
            s_nxt.rx_st  = LCU_RX_SBRK;
            s_nxt.lo_cnt = 5'h01;
          end else begin
            s_nxt.rx_st  = LCU_RX_DATA;
            s_nxt.rx_idx = 3'h0;
          end
        end
      end
      LCU_RX_DATA: begin
        if (rx_bif.half) begin
          s_nxt.rxsr   = s_r.mode[`LCU_MODE_MSB] ? {s_r.rxsr[6:0], s_r.rx_smp}
                                                 : {s_r.rx_smp, s_r.rxsr[7:1]};
          s_nxt.rx_idx = s_r.rx_idx + 3'h1;
          if (s_r.rx_idx == last_idx) begin
            s_nxt.rx_st = LCU_RX_STOP;
          end
        end
      end
      LCU_RX_STOP: begin
        if (rx_bif.half) begin
          s_nxt.rx_st = LCU_RX_IDLE;
          s_nxt.frm   = s_nxt.frm | ~s_r.rx_smp; // a clear this cycle still counts
          if (s_nxt.rx_rdy) begin
            s_nxt.ovr = 1'b1; // unread word kept
          end else begin
            s_nxt.rxbuf  = rx_word;
            s_nxt.rx_rdy = 1'b1;
          end
        end
      end
      LCU_RX_SBRK: begin
        if (rx_bif.half) begin
          if (!s_r.rx_smp) begin
            s_nxt.lo_cnt = (s_r.lo_cnt == `LCU_LO_SAT) ? s_r.lo_cnt
                                                       : s_r.lo_cnt + 5'h01;
          end else if (s_r.lo_cnt >= `LCU_SBF_MIN) begin
            s_nxt.sbf_ok               = 1'b1;
            s_nxt.mode[`LCU_MODE_SBRX] = 1'b0;
            s_nxt.rx_st                = LCU_RX_IDLE;
          end else begin
            s_nxt.sbf_err = 1'b1;
            s_nxt.rx_st   = LCU_RX_IDLE;
          end
        end
      end
      default: s_nxt.rx_st = LCU_RX_IDLE;
    endcase
    if (!rx_act) begin
      s_nxt.rx_st = LCU_RX_IDLE;
    end
  end

  // low clock enable stands for a stopped clock: everything holds
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      s_r <= RST_S;
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  sequence seq_stop_end;
    ce_i && tx_act && s_r.tx_st == LCU_TX_STOP && tx_bif.full && s_r.txfull;
  endsequence

  sequence seq_short_brk;
    ce_i && rx_act && s_r.rx_st == LCU_RX_SBRK && rx_bif.half && s_r.rx_smp
      && s_r.lo_cnt < `LCU_SBF_MIN;
  endsequence

  a_off_idle_high: assert property (ce_i && !pwr |=> lin_uart_tx_pin_o)
    else $error("tx output not high while powered off");
  a_freeze_all: assert property (!ce_i |=> $stable(s_r) && $stable(lin_uart_tx_pin_o))
    else $error("state moved while clock enable low");
  a_gap_follows: assert property (seq_stop_end |=> s_r.tx_st == LCU_TX_GAP
    ##0 (s_r.gap_cnt == 2'h0))
    else $error("no idle gap before back-to-back frame");
  a_brk_bound: assert property (s_r.tx_st == LCU_TX_BRK |-> s_r.brk_cnt <= brk_last)
    else $error("break longer than programmed");
  a_brk_low: assert property (ce_i && tx_act && s_r.tx_st == LCU_TX_BRK
    |=> lin_uart_tx_pin_o == s_r.mode[`LCU_MODE_INV])
    else $error("break not driven low");
  a_sbf_found: assert property (ce_i && rx_act && s_r.rx_st == LCU_RX_SBRK && rx_bif.half
    && s_r.rx_smp && s_r.lo_cnt >= `LCU_SBF_MIN |=> s_r.sbf_ok)
    else $error("long break not flagged");
  a_sbf_short: assert property (seq_short_brk |=> s_r.sbf_err
    && s_r.mode[`LCU_MODE_SBRX] && s_r.rx_st == LCU_RX_IDLE)
    else $error("short break mishandled");
  a_rx_restart: assert property (ce_i && rx_act && s_r.rx_st == LCU_RX_IDLE
    && s_r.rx_prev && !s_r.rx_smp |=> s_r.rx_st == LCU_RX_START)
    else $error("start edge not taken");
  a_rx7_align: assert property ($rose(s_r.rx_rdy) && !s_r.mode[`LCU_MODE_LEN8]
    |-> (s_r.mode[`LCU_MODE_MSB] ? !s_r.rxbuf[0] : !s_r.rxbuf[7]))
    else $error("7-bit word misaligned");
  a_bus_answer: assert property (ce_i && acc ##1 ce_i |-> !avs_waitrequest_o)
    else $error("bus answer late");
endmodule
`default_nettype wire

// ===== dv/lcu_line_model.sv
// lin transceiver stand-in: drives the receive line, decodes the transmit line
// assumes bit times in mclk cycles and a pulled-up bus that idles high
`timescale 1ns/100ps
`default_nettype none
module lcu_line_model (
  input  wire logic mclk_i,
  input  wire logic tx_i,
  output logic      rx_o
);
  // recessive level of the pulled-up wire
  initial rx_o = 1'b1;

  // one frame: start, n data bits, one stop, never back to back
  task automatic send(input logic [7:0] d, input int n, input logic msb, input int bt);
    @(posedge mclk_i);
    for (int i = -1; i <= n; i++) begin
      rx_o <= (i < 0) ? 1'b0 : (i == n) ? 1'b1 : d[msb ? 7 - i : i];
      repeat (bt) @(posedge mclk_i);
    end
  endtask

  // a long low period, then the bus rests high again
  task automatic send_low(input int n, input int bt);
    @(posedge mclk_i);
    rx_o <= 1'b0;
    repeat (n * bt) @(posedge mclk_i);
    rx_o <= 1'b1;
    repeat (2 * bt) @(posedge mclk_i);
  endtask

  // decode one frame from the transmit line, sampled mid-bit
  task automatic grab(input int n, input logic msb, input logic inv, input int bt,
                      output logic [7:0] d, output logic stp);
    int w;
    d = 8'h00;
    w = 0;
    // bounded hunt for the start level
    while (tx_i !== inv && w < 500) begin
      @(negedge mclk_i);
      w++;
    end
    repeat (bt / 2) @(negedge mclk_i);
    for (int i = 0; i < n; i++) begin
      repeat (bt) @(negedge mclk_i);
      d[msb ? 7 - i : i] = tx_i ^ inv;
    end
    repeat (bt) @(negedge mclk_i);
    stp = tx_i ^ inv;
  endtask
endmodule
`default_nettype wire

// ===== dv/lin_capable_uart_core_tb.sv
// self-checking bench for the lin uart core with a line model on its pins
// assumes select 0 and k 4, so one bit lasts 8 mclk cycles
`timescale 1ns/100ps
`default_nettype none
`include "lcu_cfg.svh"
module lin_capable_uart_core_tb;
  import lcu_pkg::*;
  localparam int BT = 8;   // bit time in mclk cycles
  logic        mclk_i = 1'b0;
  logic        rst_i  = 1'b1;
  logic        ce     = 1'b1;
  logic        rd     = 1'b0;
  logic        wr     = 1'b0;
  logic [4:0]  adr    = 5'h00;
  logic [31:0] wd     = 32'h00000000;
  logic [31:0] rdat;
  logic [31:0] q;
  logic        waitreq;
  logic        tx;
  logic        rx;
  logic [7:0]  d;
  logic [7:0]  got;
  logic [7:0]  ex;
  logic        stp;
  int          err_count = 0;
  int          n_tests   = 0;
  int          cyc       = 0;
  int          lo;

  always #25 mclk_i = ~mclk_i;

  // clock enable drops once to stand for a stopped clock
  lcu_core u_lcu_core (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdat),
    .avs_waitrequest_o(waitreq), .lin_uart_rx_pin_i(rx), .lin_uart_tx_pin_o(tx));
  lcu_line_model u_lcu_line_model (.mclk_i(mclk_i), .tx_i(tx), .rx_o(rx));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one avalon access, held until waitrequest is sampled low at a rising edge;
  // only the hang guard ends a wait that never completes
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] v);
    @(posedge mclk_i);
    rd <= ~w;
    wr <= w;
    adr <= a;
    wd <= {24'h000000, v};
    do begin
      @(posedge mclk_i);
    end while (waitreq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rdchk(input logic [4:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(q, {24'h000000, e});
  endtask

  // counts cycles the transmit line stays at level v, bounded
  task automatic hold_len(input logic v, output int n);
    n = 0;
    while (tx === v && n < 500) begin
      @(negedge mclk_i);
      n++;
    end
  endtask

  task automatic conclude();
    $display("compares %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // hang guard well above the expected run length
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc > 40000) begin
      err_count++;
      conclude();
    end
  end

  initial begin
    void'($urandom(32'h066E));
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    rdchk(`LCU_OFS_MODE, `LCU_RST_MODE);
    rdchk(`LCU_OFS_BAUD, `LCU_RST_BAUD);
    rdchk(`LCU_OFS_TXD, `LCU_RST_DATA);
    rdchk(`LCU_OFS_RXD, `LCU_RST_DATA);
    rdchk(5'h18, 8'h00);
    bus(1'b1, `LCU_OFS_BAUD, 8'h04);
    // powered off: the word is stored but never sent and the line stays high
    bus(1'b1, `LCU_OFS_TXD, 8'h5A);
    repeat (4 * BT) begin
      @(negedge mclk_i);
      chk({31'h0, tx}, 32'h1);
    end
    $display("test reset and stop mode done");
    // every mix of order, length and inversion, both directions
    for (int m = 0; m < 8; m++) begin
      d = 8'($urandom());
      ex = m[1] ? d : (m[0] ? (d & 8'hFE) : (d & 8'h7F));
      bus(1'b1, `LCU_OFS_MODE, {3'b111, m[0], m[1], m[2], 2'b00});
      bus(1'b1, `LCU_OFS_TXD, d);
      u_lcu_line_model.grab(m[1] ? 8 : 7, m[0], m[2], BT, got, stp);
      chk({24'h0, got}, {24'h0, ex});
      chk({31'h0, stp}, 32'h1);
      u_lcu_line_model.send(d, m[1] ? 8 : 7, m[0], BT);
      rdchk(`LCU_OFS_RXD, ex);
    end
    $display("test framing modes done");
    // break lengths for every code, transmitter alone enabled
    bus(1'b1, `LCU_OFS_MODE, 8'hC8);
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, `LCU_OFS_CTRL, {1'b1, 3'(c), 4'h0});
      hold_len(1'b1, lo);
      hold_len(1'b0, lo);
      chk(32'(lo), 32'((13 + c) * BT));
      repeat (3 * BT) @(negedge mclk_i);
    end
    $display("test break send done");
    // short low is an error and leaves break mode armed
    bus(1'b1, `LCU_OFS_MODE, 8'hA2);
    u_lcu_line_model.send_low(8, BT);
    bus(1'b0, `LCU_OFS_STAT, 8'h00);
    chk(q & 32'h60, 32'h40);
    rdchk(`LCU_OFS_MODE, 8'hA2);
    bus(1'b1, `LCU_OFS_STAT, 8'h60);
    u_lcu_line_model.send_low(12, BT);
    bus(1'b0, `LCU_OFS_STAT, 8'h00);
    chk(q & 32'h60, 32'h20);
    rdchk(`LCU_OFS_MODE, 8'hA0);
    // rate frame after a good break, as a master sends it
    u_lcu_line_model.send(8'h55, 7, 1'b0, BT);
    rdchk(`LCU_OFS_RXD, 8'h55);
    $display("test break receive done");
    // plain uart use, not lin: a second word queued behind the first
    bus(1'b1, `LCU_OFS_MODE, 8'hC8);
    d = 8'($urandom());
    bus(1'b1, `LCU_OFS_TXD, d);
    bus(1'b1, `LCU_OFS_TXD, ~d);
    u_lcu_line_model.grab(8, 1'b0, 1'b0, BT, got, stp);
    chk({24'h0, got}, {24'h0, d});
    // half a stop bit is left after the grab, then two base clocks of gap
    hold_len(1'b1, lo);
    chk(32'(lo), 32'(BT / 2 + 2));
    u_lcu_line_model.grab(8, 1'b0, 1'b0, BT, got, stp);
    chk({24'h0, got}, {24'h0, ~d});
    chk({31'h0, stp}, 32'h1);
    $display("test back-to-back done");
    // clock enable low mid start bit; ones follow, so a moving line shows
    repeat (BT) @(negedge mclk_i);
    bus(1'b1, `LCU_OFS_TXD, 8'hFF);
    repeat (4) @(posedge mclk_i);
    ce <= 1'b0;
    repeat (2 * BT) begin
      @(negedge mclk_i);
      chk({31'h0, tx}, 32'h0);
    end
    @(posedge mclk_i);
    ce <= 1'b1;
    // software reinitialises the unit once the clock is back
    bus(1'b1, `LCU_OFS_MODE, 8'h00);
    rdchk(`LCU_OFS_MODE, 8'h00);
    chk({31'h0, tx}, 32'h1);
    $display("test clock stop done");
    conclude();
  end
endmodule
`default_nettype wire
